/* File: rais_sequencer.sv */
// Reset and interrupt sequencer for an 8-bit core: reset sources, mask bit,
// pending interrupt latch, fixed-priority arbitration and vector selection.
// Assumes the core reports fetches, instruction ends, trap and return events
// on the core clock; pins and analog comparators arrive asynchronously.
// Behaviour
// RL1: Any reset vectors through the reset pair and sets the mask bit.
// RL2: After power-on hold reset for settle delay, longer while pin low.
// RL3: Pin low 1.5 machine cycles resets; run resumes cycle after release.
// RL4: Low-voltage reset drives the reset pin low as an output.
// RL5: Opcode fetch outside RAM, ROM and EEPROM resets the device.
// RL6: Watchdog reset is internal and keeps the current configuration.
// RL7: Watchdog reset source enabled by build option only.
// RL8: Low-voltage reset holds below on-level, reasserts below off-level.
// RL9: Nine maskable hardware sources plus one software trap.
// RL10: Taking an interrupt stacks registers and sets the mask bit.
// RL11: Return from handler restores the mask bit from the stack.
// RL12: Interrupts taken only at instruction end, unmasked and enabled.
// RL13: Power-on or pin reset clears every interrupt enable.
// RL14: Highest-priority pending interrupt first; external beats timer.
// RL15: Trap ignores mask, after earlier-pending, before later interrupts.
// RL16: Mask bit set blocks every maskable interrupt.
// RL17: Option bit 3 selects edge or edge-and-level external sensing.
// RL18: External latch cleared on handler entry so one more pulse is kept.
// RL19: Tick and wrap flags share the core timer vector pair.
// RL20: Wrap flag set when core counter wraps from max to zero.
// RL21: Vector pair chosen per source group.
// RL22: Interrupt entry uses five stack bytes, a call two.
// RL23: Priority follows descending vector address.
// RL24: Full 16-bit fetch address checked before the byte executes.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rais_sequencer #(
    parameter int POR_SETTLE_CYCLES = `RAIS_POR_SETTLE_CYC,
    // RL7 build option
    parameter bit WDOG_EN = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_osc_stable,
    input wire logic i_reset_pin_in,
    output logic o_reset_pin_out,
    output logic o_reset_pin_oe,
    input wire logic i_supply_below_off,
    input wire logic i_supply_above_on,
    input wire logic i_watchdog_timeout,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_addr,
    input wire logic i_instr_done,
    input wire logic i_software_trap_instr,
    input wire logic i_return_from_handler_instr,
    input wire logic i_restored_ibit,
    input wire logic i_ibit_wr,
    input wire logic i_ibit_val,
    input wire logic i_irq_n,
    input wire logic i_keyboard_strobe_flag,
    input wire logic i_periodic_tick_flag,
    input wire logic i_core_timer_tick,
    input wire logic i_slow_clock_periodic_irq,
    input wire logic i_timer16_irq,
    input wire logic i_low_supply_flag,
    input wire logic i_spi_irq,
    input wire logic i_sci_irq,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_core_reset,
    output logic o_clear_enables,
    output logic o_vector_take,
    output logic [15:0] o_vector_addr,
    output logic [2:0] o_stack_bytes,
    output logic o_ibit
);
    import rais_pkg::*;

    localparam logic [19:0] POR_CYC = 20'(POR_SETTLE_CYCLES);
    localparam logic [2:0] PIN_CYC = 3'(`RAIS_PIN_MIN_CYC);

    localparam rais_state_s RST_VAL = '{
        st: ST_POR, lv: 1'b1, ibit: 1'b1, pin_s1: 1'b1, pin_s2: 1'b1,
        irq_s1: 1'b1, irq_s2: 1'b1, irq_d: 1'b1, vec: `RAIS_VEC_RESET,
        stack: `RAIS_STACK_IRQ, default: '0};

    rais_state_s s, n;
    logic illegal, wdog, pin_hit;
    logic [5:0] pend, cand;
    logic [2:0] sel;

    function automatic logic [15:0] grp_vec(input logic [2:0] g);
        case (g)
            3'(`RAIS_G_EXT): grp_vec = `RAIS_VEC_EXT;
            3'(`RAIS_G_CORE_TIMER_IRQ): grp_vec = `RAIS_VEC_CORE_TIMER_IRQ;
            3'(`RAIS_G_TIMER16): grp_vec = `RAIS_VEC_TIMER16;
            3'(`RAIS_G_LVI): grp_vec = `RAIS_VEC_LVI;
            3'(`RAIS_G_SPI): grp_vec = `RAIS_VEC_SPI;
            default: grp_vec = `RAIS_VEC_SCI;
        endcase
    endfunction

    // RL23 lowest index wins
    function automatic logic [2:0] first_set(input logic [5:0] v);
        first_set = 3'h0;
        for (int i = `RAIS_NGRP - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction

    always_comb begin
        // RL5 RL24 full address check
        illegal = i_fetch_valid && (s.st == ST_RUN) &&
                  !((i_fetch_addr >= `RAIS_RAM_LO && i_fetch_addr <= `RAIS_RAM_HI) ||
                    (i_fetch_addr >= `RAIS_EE_LO && i_fetch_addr <= `RAIS_EE_HI) ||
                    (i_fetch_addr >= `RAIS_ROM_LO));
        // RL7 watchdog gated
        wdog = WDOG_EN && i_watchdog_timeout && (s.st == ST_RUN);
        pin_hit = (s.pin_cnt >= PIN_CYC);
        // RL9 RL17 RL19 request groups
        pend[`RAIS_G_EXT] = (s.ext_en && (s.irq_latch || (s.lvl_mode && !s.irq_s2))) ||
                            i_keyboard_strobe_flag;
        pend[`RAIS_G_CORE_TIMER_IRQ] = (s.wrap_flag && s.wrap_en) || (s.tick_flag && s.tick_en) ||
                               i_slow_clock_periodic_irq;
        pend[`RAIS_G_TIMER16] = i_timer16_irq;
        pend[`RAIS_G_LVI] = s.lvi_en && i_low_supply_flag;
        pend[`RAIS_G_SPI] = i_spi_irq;
        pend[`RAIS_G_SCI] = i_sci_irq;
        // RL15 only interrupts pending at the trap fetch go first
        cand = s.swi_pend ? (s.ibit ? 6'h00 : (pend & s.swi_snap)) : (s.ibit ? 6'h00 : pend);
        sel = first_set(cand);

        n = s;
        n.take = 1'b0;
        n.clr_en = 1'b0;
        n.rdata = 8'h00;
        n.pin_s1 = i_reset_pin_in;
        n.pin_s2 = s.pin_s1;
        n.irq_s1 = i_irq_n;
        n.irq_s2 = s.irq_s1;
        n.irq_d = s.irq_s2;
        n.osc_s1 = i_osc_stable;
        n.osc_s2 = s.osc_s1;
        n.on_s1 = i_supply_above_on;
        n.on_s2 = s.on_s1;
        n.off_s1 = i_supply_below_off;
        n.off_s2 = s.off_s1;
        n.pin_cnt = s.pin_s2 ? 3'h0 : (pin_hit ? s.pin_cnt : s.pin_cnt + 3'h1);

        // RL8 hysteresis between the two thresholds
        if (s.off_s2) begin
            n.lv = 1'b1;
        end else if (s.on_s2) begin
            n.lv = 1'b0;
        end

        if (i_wr) begin
            case (i_addr)
                `RAIS_REG_OPTION: begin
                    n.lvl_mode = i_wdata[`RAIS_OPT_LEVEL];
                    n.ext_en = i_wdata[`RAIS_OPT_EXT_EN];
                    n.lvi_en = i_wdata[`RAIS_OPT_LVI_EN];
                end
                `RAIS_REG_CORE_TIMER_IRQ: begin
                    // Flags clear on a written zero only
                    n.wrap_flag = s.wrap_flag && i_wdata[`RAIS_CT_WRAP_FLAG];
                    n.tick_flag = s.tick_flag && i_wdata[`RAIS_CT_TICK_FLAG];
                    n.wrap_en = i_wdata[`RAIS_CT_WRAP_EN];
                    n.tick_en = i_wdata[`RAIS_CT_TICK_EN];
                end
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `RAIS_REG_OPTION: begin
                    n.rdata[`RAIS_OPT_LEVEL] = s.lvl_mode;
                    n.rdata[`RAIS_OPT_EXT_EN] = s.ext_en;
                    n.rdata[`RAIS_OPT_LVI_EN] = s.lvi_en;
                    n.rdata[`RAIS_OPT_LVI_FLAG] = i_low_supply_flag;
                end
                `RAIS_REG_CORE_TIMER_IRQ: begin
                    n.rdata[`RAIS_CT_WRAP_FLAG] = s.wrap_flag;
                    n.rdata[`RAIS_CT_TICK_FLAG] = s.tick_flag;
                    n.rdata[`RAIS_CT_WRAP_EN] = s.wrap_en;
                    n.rdata[`RAIS_CT_TICK_EN] = s.tick_en;
                end
                `RAIS_REG_STATUS: n.rdata = {s.irq_latch, s.swi_pend, s.cause, s.lv, s.ibit};
                `RAIS_REG_COUNT: n.rdata = s.ctr;
                default: n.rdata = 8'h00;
            endcase
        end

        // RL20 wrap sets the flag; set wins over a clearing write
        if (i_core_timer_tick) begin
            n.ctr = s.ctr + 8'h01;
            if (s.ctr == `RAIS_CTR_MAX) begin
                n.wrap_flag = 1'b1;
            end
        end
        if (i_periodic_tick_flag) begin
            n.tick_flag = 1'b1;
        end

        case (s.st)
            ST_POR: begin
                // RL2 settle counted from a running oscillator
                if (s.osc_s2) begin
                    n.por_cnt = s.por_cnt + 20'h1;
                    if (s.por_cnt >= POR_CYC - 20'h1) begin
                        n.st = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // RL2 RL3 RL1 leave once the pin is high, through the reset pair
                if (s.pin_s2 && !s.lv) begin
                    n.st = ST_RUN;
                    n.vec = `RAIS_VEC_RESET;
                    n.take = 1'b1;
                    n.ibit = 1'b1;
                    n.swi_pend = 1'b0;
                end
            end
            ST_RUN: begin
                if (s.lv || pin_hit) begin
                    // RL3 RL13 external reset clears the enables
                    n.st = ST_HOLD;
                    n.clr_en = 1'b1;
                    n.ext_en = 1'b0;
                    n.lvi_en = 1'b0;
                    n.wrap_en = 1'b0;
                    n.tick_en = 1'b0;
                    n.ibit = 1'b1;
                    n.cause = {s.lv, 1'b1, 2'b00};
                end else if (illegal || wdog) begin
                    // RL6 internal reset keeps the configuration
                    n.st = ST_HOLD;
                    n.ibit = 1'b1;
                    n.cause = {2'b00, wdog, illegal};
                end else begin
                    // RL11 mask restored from the stack copy
                    if (i_return_from_handler_instr) begin
                        n.ibit = i_restored_ibit;
                    end
                    if (i_ibit_wr) begin
                        n.ibit = i_ibit_val;
                    end
                    if (i_software_trap_instr) begin
                        n.swi_pend = 1'b1;
                        n.swi_snap = s.ibit ? 6'h00 : pend;
                    end
                    // RL12 RL16 arbitrate at instruction end only
                    if (i_instr_done) begin
                        if (cand != 6'h00) begin
                            // RL10 RL14 RL21 RL22 take the best group
                            n.take = 1'b1;
                            n.vec = grp_vec(sel);
                            n.ibit = 1'b1;
                            n.stack = `RAIS_STACK_IRQ;
                            n.swi_snap[sel] = 1'b0;
                            if (sel == 3'(`RAIS_G_EXT)) begin
                                // RL18 handler entry frees the latch
                                n.irq_latch = 1'b0;
                            end
                        end else if (s.swi_pend) begin
                            // RL15 trap ignores the mask
                            n.take = 1'b1;
                            n.vec = `RAIS_VEC_SWI;
                            n.ibit = 1'b1;
                            n.stack = `RAIS_STACK_IRQ;
                            n.swi_pend = 1'b0;
                        end
                    end
                end
            end
            default: n.st = ST_POR;
        endcase

        // RL17 RL18 falling edge latched; set wins over entry clear
        if (s.irq_d && !s.irq_s2) begin
            n.irq_latch = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= RST_VAL;
        end else begin
            s <= n;
        end
    end

    // RL1 RL24 reset asserted in the fetch cycle itself
    assign o_core_reset = (s.st != ST_RUN) || illegal || wdog;
    // RL4 open-drain drive of the reset pin
    assign o_reset_pin_out = 1'b0;
    assign o_reset_pin_oe = s.lv;
    assign o_rdata = s.rdata;
    assign o_clear_enables = s.clr_en;
    assign o_vector_take = s.take;
    assign o_vector_addr = s.vec;
    assign o_stack_bytes = s.stack;
    assign o_ibit = s.ibit;

    sequence pin_low_run;
        (s.st == ST_RUN && !s.lv && !s.pin_s2) [*3];
    endsequence

    a_reset_vec_mask: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
        (s.st == ST_HOLD && n.st == ST_RUN) |=> (o_vector_addr == `RAIS_VEC_RESET && o_ibit))
        else $error("reset exit without reset vector or mask");
    a_por_holds: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL2
        (s.st == ST_POR) |-> o_core_reset)
        else $error("core released during power-on settle");
    a_pin_resets: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL3
        pin_low_run |=> (s.st == ST_HOLD))
        else $error("held pin low did not reset");
    a_lv_drives_pin: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL4
        $rose(s.lv) |-> (o_reset_pin_oe && !o_reset_pin_out))
        else $error("low-voltage reset not driving pin");
    a_illegal_fetch: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL5
        (s.st == ST_RUN && i_fetch_valid && i_fetch_addr < `RAIS_RAM_LO) |->
        (o_core_reset ##1 s.st == ST_HOLD))
        else $error("illegal fetch not reset");
    a_wdog_keeps_en: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL6
        (wdog && !illegal && !s.lv && !pin_hit) |=> (!o_clear_enables && $stable(s.ext_en)))
        else $error("watchdog reset cleared enables");
    a_take_masks: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL10
        o_vector_take |-> (o_ibit && o_stack_bytes == `RAIS_STACK_IRQ))
        else $error("interrupt entry without mask or stacking");
    a_mask_blocks: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL16
        (s.st == ST_RUN && s.ibit && !s.swi_pend && !i_software_trap_instr) |=> !o_vector_take)
        else $error("maskable interrupt taken while masked");
    a_ext_over_tmr: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL14
        (s.st == ST_RUN && i_instr_done && cand[`RAIS_G_EXT] && !illegal && !wdog &&
         !s.lv && !pin_hit) |=> (o_vector_take && o_vector_addr == `RAIS_VEC_EXT))
        else $error("external interrupt lost priority");
    a_wrap_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL20
        (i_core_timer_tick && s.ctr == `RAIS_CTR_MAX) |=> (s.wrap_flag && s.ctr == 8'h00))
        else $error("wrap flag not set on counter wrap");
    a_pin_clears_en: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL13
        (s.st == ST_RUN && pin_hit) |=> (o_clear_enables && !s.ext_en && !s.wrap_en))
        else $error("pin reset kept enables");
endmodule // rais_sequencer

/* File: rais_cfg.svh */
// Offsets, encodings and timing constants of the reset and interrupt sequencer.
// Assumes inclusion by bare name from the package; the sequencer uses its macros through that.
`ifndef RAIS_CFG_SVH
`define RAIS_CFG_SVH

// Vector pairs (high byte address)
`define RAIS_VEC_RESET 16'hfffe
`define RAIS_VEC_SWI 16'hfffc
`define RAIS_VEC_EXT 16'hfffa
`define RAIS_VEC_CORE_TIMER_IRQ 16'hfff8
`define RAIS_VEC_TIMER16 16'hfff6
`define RAIS_VEC_LVI 16'hfff4
`define RAIS_VEC_SPI 16'hfff2
`define RAIS_VEC_SCI 16'hfff0

// Legal opcode fetch ranges
`define RAIS_RAM_LO 16'h0068
`define RAIS_RAM_HI 16'h03ff
`define RAIS_EE_LO 16'h0400
`define RAIS_EE_HI 16'h04ff
`define RAIS_ROM_LO 16'h8000

// Stack use per entry
`define RAIS_STACK_IRQ 3'h5
`define RAIS_STACK_CALL 3'h2

// Core timer counter limit
`define RAIS_CTR_MAX 8'hff

// Timing: machine cycle is the bus clock
`define RAIS_CLK_PERIOD_PS 25000
`define RAIS_PIN_MIN_PS 37500
`define RAIS_PIN_MIN_CYC ((`RAIS_PIN_MIN_PS + `RAIS_CLK_PERIOD_PS - 1) / `RAIS_CLK_PERIOD_PS)
`define RAIS_POR_SETTLE_CYC 4096

// Register indices
`define RAIS_REG_OPTION 8'h00
`define RAIS_REG_CORE_TIMER_IRQ 8'h01
`define RAIS_REG_STATUS 8'h02
`define RAIS_REG_COUNT 8'h03

// Option register fields
`define RAIS_OPT_LEVEL 3
`define RAIS_OPT_EXT_EN 2
`define RAIS_OPT_LVI_EN 1
`define RAIS_OPT_LVI_FLAG 0

// Core timer control and status fields
`define RAIS_CT_WRAP_FLAG 7
`define RAIS_CT_TICK_FLAG 6
`define RAIS_CT_WRAP_EN 5
`define RAIS_CT_TICK_EN 4

// Interrupt groups, index 0 is the highest priority
`define RAIS_NGRP 6
`define RAIS_G_EXT 0
`define RAIS_G_CORE_TIMER_IRQ 1
`define RAIS_G_TIMER16 2
`define RAIS_G_LVI 3
`define RAIS_G_SPI 4
`define RAIS_G_SCI 5

`endif

/* File: rais_pkg.sv */
// Types of the reset and interrupt sequencer.
// Assumes rais_cfg.svh is on the include path.
package rais_pkg;
    `include "rais_cfg.svh"

    typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_RUN} rais_state_e;

    typedef struct packed {
        rais_state_e st;
        logic [19:0] por_cnt;
        logic [2:0] pin_cnt;
        logic pin_s1, pin_s2;
        logic irq_s1, irq_s2, irq_d;
        logic osc_s1, osc_s2;
        logic on_s1, on_s2;
        logic off_s1, off_s2;
        logic lv;
        logic ibit;
        logic irq_latch;
        logic swi_pend;
        logic [5:0] swi_snap;
        logic [7:0] ctr;
        logic wrap_flag, tick_flag, wrap_en, tick_en;
        logic lvl_mode, ext_en, lvi_en;
        logic [3:0] cause;
        logic [15:0] vec;
        logic take;
        logic [2:0] stack;
        logic clr_en;
        logic [7:0] rdata;
    } rais_state_s;
endpackage

/* File: rais_core_model.sv */
// Behavioural model of the core sequencer that faces the interrupt block.
// Assumes one core clock; every signal moves just after a rising edge.
`timescale 1ns/1ps
module rais_core_model (
    input wire logic i_core_clk,
    input wire logic i_core_reset,
    output logic o_instr_done,
    output logic o_trap,
    output logic o_ret,
    output logic o_restored,
    output logic o_ibit_wr,
    output logic o_ibit_val,
    output logic o_fetch_valid,
    output logic [15:0] o_fetch_addr,
    output logic o_pin_low
);
    initial begin
        {o_instr_done, o_trap, o_ret, o_restored, o_ibit_wr, o_ibit_val} = 6'h00;
        o_fetch_valid = 1'b0;
        o_fetch_addr = 16'h0000;
        // Pin held low at power-up, as a board reset circuit would
        o_pin_low = 1'b1;
    end

    task automatic boundary();
        @(posedge i_core_clk);
        o_instr_done <= 1'b1;
        @(posedge i_core_clk);
        o_instr_done <= 1'b0;
    endtask

    task automatic trap();
        @(posedge i_core_clk);
        o_trap <= 1'b1;
        @(posedge i_core_clk);
        o_trap <= 1'b0;
    endtask

    task automatic ret(input logic v);
        @(posedge i_core_clk);
        o_ret <= 1'b1;
        o_restored <= v;
        @(posedge i_core_clk);
        o_ret <= 1'b0;
        o_restored <= ~v;
    endtask

    task automatic mask(input logic v);
        @(posedge i_core_clk);
        o_ibit_wr <= 1'b1;
        o_ibit_val <= v;
        @(posedge i_core_clk);
        o_ibit_wr <= 1'b0;
        o_ibit_val <= ~v;
    endtask

    // full address per fetch; address scrambled once released
    task automatic fetch(input logic [15:0] a, output logic rst);
        @(posedge i_core_clk);
        o_fetch_valid <= 1'b1;
        o_fetch_addr <= a;
        #1 rst = i_core_reset;
        @(posedge i_core_clk);
        o_fetch_valid <= 1'b0;
        o_fetch_addr <= ~a;
    endtask

    // pin low well over 1.5 cycles
    task automatic pin_reset(input int n);
        @(posedge i_core_clk);
        o_pin_low <= 1'b1;
        repeat (n) @(posedge i_core_clk);
    endtask
endmodule // rais_core_model

/* File: reset_and_interrupt_sequencer_tb.sv */
// Self-checking bench for the reset and interrupt sequencer.
// Assumes the core model file is compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module reset_and_interrupt_sequencer_tb;
    import rais_pkg::*;
    logic i_core_clk = 1'b0, i_rstn = 1'b0, i_osc_stable = 1'b0;
    logic i_supply_below_off = 1'b0, i_supply_above_on = 1'b1, i_watchdog_timeout = 1'b0;
    logic i_irq_n = 1'b1, i_periodic_tick_flag = 1'b0, i_core_timer_tick = 1'b0;
    logic [5:0] src = 6'h00;
    wire kbd = src[0], slow_clock_periodic_irq = src[1], t16 = src[2], lvf = src[3], spi = src[4], sci = src[5];
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d;
    logic i_wr = 1'b0, i_rd = 1'b0, rst;
    logic done, trp, rt, rstr, iwr, ival, fv, plow, pin_out, pin_oe;
    logic [15:0] fa, o_vector_addr;
    logic o_core_reset, o_vector_take, o_ibit, o_clear_enables;
    logic [2:0] o_stack_bytes;
    int n_mismatch = 0, checks = 0;
    // Open-drain reset pin with pull-up
    wire pin_wire = !(plow || (pin_oe && !pin_out));
    always #12.5 i_core_clk = ~i_core_clk;
    rais_core_model rais_core_model_i (.i_core_clk(i_core_clk), .i_core_reset(o_core_reset),
        .o_instr_done(done), .o_trap(trp), .o_ret(rt), .o_restored(rstr), .o_ibit_wr(iwr),
        .o_ibit_val(ival), .o_fetch_valid(fv), .o_fetch_addr(fa), .o_pin_low(plow));
    rais_sequencer #(.POR_SETTLE_CYCLES(8), .WDOG_EN(1'b1)) rais_sequencer_i (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_osc_stable(i_osc_stable),
        .i_reset_pin_in(pin_wire), .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
        .i_supply_below_off(i_supply_below_off), .i_supply_above_on(i_supply_above_on),
        .i_watchdog_timeout(i_watchdog_timeout), .i_fetch_valid(fv), .i_fetch_addr(fa),
        .i_instr_done(done), .i_software_trap_instr(trp), .i_return_from_handler_instr(rt),
        .i_restored_ibit(rstr), .i_ibit_wr(iwr), .i_ibit_val(ival), .i_irq_n(i_irq_n),
        .i_keyboard_strobe_flag(kbd), .i_periodic_tick_flag(i_periodic_tick_flag),
        .i_core_timer_tick(i_core_timer_tick), .i_slow_clock_periodic_irq(slow_clock_periodic_irq),
        .i_timer16_irq(t16), .i_low_supply_flag(lvf), .i_spi_irq(spi),
        .i_sci_irq(sci), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_core_reset(o_core_reset), .o_clear_enables(o_clear_enables),
        .o_vector_take(o_vector_take), .o_vector_addr(o_vector_addr),
        .o_stack_bytes(o_stack_bytes), .o_ibit(o_ibit));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_core_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        #1;
        while (o_vector_take !== 1'b1 && n < 300) begin @(posedge i_core_clk); #1; n++; end
        `CHK(o_vector_take, 1'b1)
        `CHK(o_vector_addr, 16'hfffe)
        `CHK(o_ibit, 1'b1)
    endtask
    task automatic bnd(input logic t, input logic [15:0] v);
        rais_core_model_i.boundary();
        #1 `CHK(o_vector_take, t)
        if (t) begin
            `CHK(o_vector_addr, v)
            `CHK(o_ibit, 1'b1)
            `CHK(o_stack_bytes, 3'h5)
        end
    endtask
    task automatic unmask_bnd(input logic t, input logic [15:0] v);
        rais_core_model_i.mask(1'b0);
        bnd(t, v);
    endtask

    task automatic t_power_on();
        repeat (3) @(posedge i_core_clk);
        #1 `CHK(o_core_reset, 1'b1)
        `CHK(o_vector_addr, 16'hfffe)
        i_rstn <= 1'b1;
        i_osc_stable <= 1'b1;
        repeat (30) @(posedge i_core_clk);
        #1 `CHK(o_core_reset, 1'b1)
        rais_core_model_i.o_pin_low <= 1'b0;
        wait_run();
    endtask
    task automatic t_fetch();
        logic [15:0] a[9] = '{16'h0068, 16'h03ff, 16'h0400, 16'h04ff, 16'h8000,
                              16'hffff, 16'h0067, 16'h0500, 16'h7fff};
        for (int k = 0; k < 9; k++) begin
            rais_core_model_i.fetch(a[k], rst);
            `CHK(rst, (k > 5))
            if (k > 5) wait_run();
        end
    endtask
    task automatic t_wdog();
        wr(8'h00, 8'h0c);
        @(posedge i_core_clk);
        i_watchdog_timeout <= 1'b1;
        #1 `CHK(o_core_reset, 1'b1)
        @(posedge i_core_clk);
        i_watchdog_timeout <= 1'b0;
        #1 `CHK(o_clear_enables, 1'b0)
        wait_run();
        rd(8'h00, d);
        `CHK(d & 8'h0e, 8'h0c)
        rd(8'h02, d);
        `CHK(d, 8'h09)
    endtask
    task automatic t_prio();
        wr(8'h00, 8'h06);
        src <= 6'h3f;
        for (int k = 0; k < 6; k++) begin
            unmask_bnd(1'b1, 16'hfffa - 16'(2 * k));
            src[k] <= 1'b0;
        end
        src <= 6'h04;
        bnd(1'b0, 16'h0000);
        unmask_bnd(1'b1, 16'hfff6);
        src <= 6'h00;
    endtask
    task automatic t_ext();
        wr(8'h00, 8'h04);
        i_irq_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        unmask_bnd(1'b1, 16'hfffa);
        unmask_bnd(1'b0, 16'h0000);
        rais_core_model_i.mask(1'b1);
        i_irq_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_irq_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_irq_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        unmask_bnd(1'b1, 16'hfffa);
        unmask_bnd(1'b0, 16'h0000);
        wr(8'h00, 8'h0c);
        i_irq_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        unmask_bnd(1'b1, 16'hfffa);
        unmask_bnd(1'b1, 16'hfffa);
        i_irq_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic t_trap();
        rais_core_model_i.trap();
        bnd(1'b1, 16'hfffc);
        rais_core_model_i.mask(1'b0);
        src <= 6'h04;
        rais_core_model_i.trap();
        bnd(1'b1, 16'hfff6);
        src <= 6'h00;
        bnd(1'b1, 16'hfffc);
        rais_core_model_i.ret(1'b0);
        #1 `CHK(o_ibit, 1'b0)
        rais_core_model_i.ret(1'b1);
        #1 `CHK(o_ibit, 1'b1)
    endtask
    task automatic t_timer();
        wr(8'h01, 8'h20);
        repeat (256) begin
            @(posedge i_core_clk) i_core_timer_tick <= 1'b1;
            @(posedge i_core_clk) i_core_timer_tick <= 1'b0;
        end
        rd(8'h03, d);
        `CHK(d, 8'h00)
        rd(8'h01, d);
        `CHK(d[7], 1'b1)
        unmask_bnd(1'b1, 16'hfff8);
        wr(8'h01, 8'h10);
        @(posedge i_core_clk) i_periodic_tick_flag <= 1'b1;
        @(posedge i_core_clk) i_periodic_tick_flag <= 1'b0;
        unmask_bnd(1'b1, 16'hfff8);
        wr(8'h01, 8'h30);
        wr(8'h00, 8'h06);
    endtask
    task automatic t_pin();
        rais_core_model_i.pin_reset(5);
        #1 `CHK(o_core_reset, 1'b1)
        `CHK(o_clear_enables, 1'b1)
        rais_core_model_i.o_pin_low <= 1'b0;
        wait_run();
        rd(8'h02, d);
        `CHK(d, 8'h11)
        rd(8'h00, d);
        `CHK(d & 8'h06, 8'h00)
        rd(8'h01, d);
        `CHK(d & 8'h30, 8'h00)
    endtask
    task automatic t_low_supply();
        i_supply_below_off <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        #1 `CHK(pin_oe, 1'b1)
        `CHK(pin_wire, 1'b0)
        `CHK(o_core_reset, 1'b1)
        i_supply_below_off <= 1'b0;
        i_supply_above_on <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        #1 `CHK(o_core_reset, 1'b1)
        i_supply_above_on <= 1'b1;
        wait_run();
        `CHK(pin_oe, 1'b0)
        i_supply_above_on <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        #1 `CHK(o_core_reset, 1'b0)
        i_supply_above_on <= 1'b1;
    endtask

    initial begin
        #(25ns * 20000);
        n_mismatch++;
        summarize();
    end
    initial begin
        t_power_on();
        t_fetch();
        t_wdog();
        t_prio();
        t_ext();
        t_trap();
        t_timer();
        t_pin();
        t_low_supply();
        summarize();
    end
endmodule // reset_and_interrupt_sequencer_tb
